/* hdl/flexray_clock_sync_poc.sv */
// Purpose: Clock sync counting, rate correction and protocol operation control
// Assumes: Link-side events are one-cycle pulses synchronous to core_clk
// Notes: Registers reached over APB; one level interrupt output
//
// Function
// - Rate adjustment waits three cycles after integration
// - Ignore start-up frames past sync maximum
// - Overflow flag only from sync count, no state change
// - Rate within damping band becomes zero
// - Late idle stops slot counting for segment
// - Baud 00/01/10 selects 10/5/2.5; loop-back only 10
// - Initialize schedule always full length
// - Correct offset after first pair or abort
// - Valid wake-up pattern moves listen to ready
// - Keep counting symbols after ready transition
// - Ready command ignored in ready
// - Allow-coldstart command clears coldstart inhibit
// - Halt keeps slot mode until default config
// - One wake-up pattern per two symbols
// - Missing odd-cycle sync frames set missing-rate flag
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module flexray_clock_sync_poc #(
  parameter int SYNC_MAX_W = 4,
  parameter int INIT_SCHED_LEN = poc_pkg::INIT_SCHED_MT,
  parameter int IDLE_PHASE = poc_pkg::DYN_IDLE_PHASE
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic macrotick,
  input wire logic cycle_start,
  input wire logic even_cycle,
  input wire logic sync_frame_rx,
  input wire logic startup_frame_rx,
  input wire logic calc_rate_valid,
  input wire logic [11:0] calc_rate,
  input wire logic [15:0] cycle_offset,
  input wire logic [1:0] wus_rx,
  input wire logic dyn_frame_end,
  input wire logic channel_idle,
  input wire logic dyn_seg_end,
  input wire logic slot_tick,
  output logic irq,
  output logic [11:0] rate_correction,
  output logic [10:0] slot_counter,
  output logic slot_count_stopped,
  output logic loopback_active,
  output logic [1:0] baud_code
);
  import poc_pkg::*;

  initial begin
    if (SYNC_MAX_W < 1 || SYNC_MAX_W > 8 || INIT_SCHED_LEN < 1 || IDLE_PHASE < 1) begin
      $error("flexray_clock_sync_poc: unsupported parameter value");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [31:0] config_reg;
  logic [15:0] offset_corr_out;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] events;
  logic cmd_pend;
  logic [3:0] cmd_code;
  poc_state_t state;
  logic [1:0] slot_mode_status;
  logic [2:0] wakeup_status_vector;
  logic coldstart_inhibit_flag;
  logic [11:0] rate_correction_status;

  wire access = psel && penable && !pready;
  wire done = psel && penable && pready;
  wire wr_done = done && pwrite;
  wire hit_cmd = paddr == OFF_CMD;
  wire hit_cfg = paddr == OFF_CONFIG;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_rate = paddr == OFF_RATE;
  wire hit_is = paddr == OFF_IRQ_STAT;
  wire hit_ie = paddr == OFF_IRQ_EN;
  wire hit_ic = paddr == OFF_IRQ_CLR;
  wire hit_tim = paddr == OFF_TIMING;
  wire mapped = hit_cmd | hit_cfg | hit_stat | hit_rate | hit_is | hit_ie | hit_ic | hit_tim;
  wire [IRQ_W-1:0] clr_mask = (wr_done && hit_ic) ? pwdata[IRQ_W-1:0] : '0;
  wire [31:0] rd_mux =
    hit_cfg ? config_reg :
    hit_stat ? {15'h0000, coldstart_inhibit_flag, 1'b0, wakeup_status_vector,
                slot_mode_status, 1'b0, state} :
    hit_rate ? {20'h00000, rate_correction_status} :
    hit_is ? {{(32-IRQ_W){1'b0}}, irq_stat} :
    hit_ie ? {{(32-IRQ_W){1'b0}}, irq_en} :
    hit_tim ? {16'h0000, offset_corr_out} : 32'h0000_0000;

  wire [1:0] baud_prescaler_field = config_reg[1:0];
  wire loopback_req = config_reg[2];
  wire all_slot_cfg = config_reg[3];
  wire [SYNC_MAX_W-1:0] sync_node_max = config_reg[4 +: SYNC_MAX_W];
  wire [7:0] drift_damping = config_reg[19:12];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      config_reg <= CONFIG_RST;
      offset_corr_out <= 16'h0000;
      irq_en <= '0;
    end else if (wr_done) begin
      if (hit_cfg) config_reg <= pwdata;
      if (hit_tim) offset_corr_out <= pwdata[15:0];
      if (hit_ie) irq_en <= pwdata[IRQ_W-1:0];
    end
  end

  // Command waits one clock so the state logic sees a stable code
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_pend <= 1'b0;
      cmd_code <= 4'h0;
    end else begin
      cmd_pend <= wr_done && hit_cmd;
      cmd_code <= (wr_done && hit_cmd) ? pwdata[3:0] : cmd_code;
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr_mask) | events;
      irq <= |(((irq_stat & ~clr_mask) | events) & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud and loop-back
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      baud_code <= BAUD_10M;
      loopback_active <= 1'b0;
    end else begin
      baud_code <= (baud_prescaler_field == BAUD_5M) ? BAUD_5M :
                   (baud_prescaler_field == BAUD_2M5) ? BAUD_2M5 : BAUD_10M;
      // Lower rates falsify looped data, so refuse them
      loopback_active <= loopback_req && baud_prescaler_field == BAUD_10M;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync and start-up frame counting
  logic [7:0] sync_cnt;
  logic [7:0] odd_sync_cnt;
  logic [7:0] startup_nodes;
  logic cur_even;
  wire pair_end = cycle_start && even_cycle;
  wire [7:0] sync_max8 = 8'(sync_node_max);
  wire sync_over = sync_frame_rx && sync_cnt >= sync_max8;
  wire startup_ok = startup_frame_rx && cur_even && sync_cnt <= sync_max8;
  wire missing_term = pair_end && odd_sync_cnt == 8'h00 &&
                      (state == ST_INTEG_CHECK || state == ST_NORMAL_ACTIVE);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_cnt <= 8'h00;
      odd_sync_cnt <= 8'h00;
      startup_nodes <= 8'h00;
      cur_even <= 1'b0;
    end else if (cycle_start) begin
      sync_cnt <= 8'h00;
      cur_even <= even_cycle;
      if (even_cycle) startup_nodes <= 8'h00;
      if (!even_cycle) odd_sync_cnt <= 8'h00;
    end else begin
      if (sync_frame_rx && sync_cnt != 8'hFF) sync_cnt <= sync_cnt + 8'h01;
      if (sync_frame_rx && !cur_even && odd_sync_cnt != 8'hFF)
        odd_sync_cnt <= odd_sync_cnt + 8'h01;
      if (startup_ok && startup_nodes != 8'hFF) startup_nodes <= startup_nodes + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate correction
  logic [1:0] cycles_integ;
  wire [11:0] rate_mag = calc_rate[11] ? 12'(-calc_rate) : calc_rate;
  wire [11:0] rate_damped = (rate_mag <= {4'h0, drift_damping}) ? 12'h000 : calc_rate;
  wire in_integ = state == ST_INTEG_CHECK || state == ST_NORMAL_ACTIVE;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cycles_integ <= 2'h0;
      rate_correction <= 12'h000;
      rate_correction_status <= 12'h000;
    end else begin
      if (!in_integ) cycles_integ <= 2'h0;
      else if (cycle_start && cycles_integ != 2'(RATE_HOLD_CYCLES)) cycles_integ <= cycles_integ + 2'h1;
      if (calc_rate_valid) rate_correction_status <= rate_damped;
      if (calc_rate_valid && cycles_integ == 2'(RATE_HOLD_CYCLES)) rate_correction <= rate_damped;
      else if (!in_integ) rate_correction <= 12'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dynamic segment slot counting
  logic idle_wait;
  logic [7:0] idle_cnt;
  wire idle_late = idle_wait && !channel_idle && idle_cnt >= 8'(IDLE_PHASE);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idle_wait <= 1'b0;
      idle_cnt <= 8'h00;
      slot_count_stopped <= 1'b0;
      slot_counter <= 11'h000;
    end else begin
      if (dyn_frame_end) idle_wait <= 1'b1;
      else if (channel_idle || dyn_seg_end || idle_late) idle_wait <= 1'b0;
      idle_cnt <= (idle_wait && !dyn_frame_end) ? idle_cnt + 8'h01 : 8'h00;
      // Stays stopped until the segment ends to avoid a collision
      if (dyn_seg_end || cycle_start) slot_count_stopped <= 1'b0;
      else if (idle_late) slot_count_stopped <= 1'b1;
      if (cycle_start) slot_counter <= 11'h001;
      else if (slot_tick && !slot_count_stopped && !idle_late) slot_counter <= slot_counter + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up symbol pairing per channel
  logic [1:0] wup_valid;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_wus
      logic half;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          half <= 1'b0;
        end else if (wus_rx[ch]) begin
          // Not cleared on the state change, so pairing carries on
          half <= !half;
        end
      end
      assign wup_valid[ch] = wus_rx[ch] && half;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Protocol operation control
  logic [7:0] sched_cnt;
  logic pair_seen;
  wire [15:0] off_mag = cycle_offset[15] ? 16'(-cycle_offset) : cycle_offset;
  wire is_cmd_ready = cmd_pend && cmd_code == CMD_READY;
  wire is_cmd_halt = cmd_pend && (cmd_code == CMD_HALT || cmd_code == CMD_FREEZE);
  wire is_cmd_config = cmd_pend && cmd_code == CMD_CONFIG;
  wire startup_run = state == ST_INIT_SCHEDULE || state == ST_INTEG_CHECK ||
                     state == ST_ABORT_STARTUP || state == ST_NORMAL_ACTIVE;
  wire wup_rx = state == ST_WAKEUP_LISTEN && |wup_valid;
  poc_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_DEFAULT_CONFIG: if (is_cmd_config) next_state = ST_CONFIG;
      ST_CONFIG: if (is_cmd_ready) next_state = ST_READY;
      ST_READY: begin
        if (is_cmd_config) next_state = ST_CONFIG;
        else if (cmd_pend && cmd_code == CMD_WAKEUP) next_state = ST_WAKEUP_LISTEN;
        else if (cmd_pend && cmd_code == CMD_RUN) next_state = ST_INIT_SCHEDULE;
      end
      ST_WAKEUP_LISTEN: if (wup_rx || is_cmd_ready) next_state = ST_READY;
      ST_INIT_SCHEDULE: if (macrotick && sched_cnt == 8'h01) next_state = ST_INTEG_CHECK;
      // First even start opens the pair; judge only when the next one closes it
      ST_INTEG_CHECK: begin
        if (pair_end && pair_seen) begin
          if (off_mag < offset_corr_out && startup_nodes != 8'h00) next_state = ST_NORMAL_ACTIVE;
          else next_state = ST_ABORT_STARTUP;
        end
      end
      ST_ABORT_STARTUP: next_state = ST_INIT_SCHEDULE;
      ST_NORMAL_ACTIVE: next_state = ST_NORMAL_ACTIVE;
      ST_HALT: if (is_cmd_config) next_state = ST_DEFAULT_CONFIG;
      default: next_state = ST_DEFAULT_CONFIG;
    endcase
    if (startup_run && is_cmd_ready) next_state = ST_READY;
    if ((startup_run || state == ST_READY) && is_cmd_halt) next_state = ST_HALT;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_DEFAULT_CONFIG;
      sched_cnt <= 8'h00;
      pair_seen <= 1'b0;
      slot_mode_status <= SLOT_SINGLE;
      coldstart_inhibit_flag <= 1'b1;
      wakeup_status_vector <= 3'h0;
    end else begin
      state <= next_state;
      // Loaded afresh on every entry, even after an abort
      if (next_state == ST_INIT_SCHEDULE && state != ST_INIT_SCHEDULE)
        sched_cnt <= 8'(INIT_SCHED_LEN);
      else if (macrotick && sched_cnt != 8'h00) sched_cnt <= sched_cnt - 8'h01;
      if (state != ST_INTEG_CHECK) pair_seen <= 1'b0;
      else if (pair_end) pair_seen <= 1'b1;
      if (next_state == ST_NORMAL_ACTIVE && state != ST_NORMAL_ACTIVE)
        slot_mode_status <= all_slot_cfg ? SLOT_ALL : SLOT_SINGLE;
      else if (state == ST_HALT && next_state == ST_DEFAULT_CONFIG)
        slot_mode_status <= SLOT_SINGLE;
      if (cmd_pend && cmd_code == CMD_ALLOW_COLDSTART) coldstart_inhibit_flag <= 1'b0;
      else if (is_cmd_ready && state != ST_READY) coldstart_inhibit_flag <= 1'b1;
      if (wup_rx) wakeup_status_vector <= WSV_RX_WUP;
    end
  end

  // Overflow is an event only; state logic never reads it
  always_comb begin
    events = '0;
    events[IRQ_SFO] = sync_over;
    events[IRQ_WST] = wup_rx;
    events[IRQ_WUPA +: 2] = wup_valid;
    events[IRQ_MRCS] = missing_term;
  end
endmodule

/* hdl/poc_pkg.sv */
// Purpose: Shared constants for the clock sync and protocol control block
// Assumes: APB byte addresses, 32-bit data
// Notes: Command codes other than allow-coldstart are local choices
package poc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RATE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_TIMING = 8'h1C;
  // Protocol command codes
  localparam logic [3:0] CMD_CONFIG = 4'h1;
  localparam logic [3:0] CMD_READY = 4'h2;
  localparam logic [3:0] CMD_WAKEUP = 4'h3;
  localparam logic [3:0] CMD_RUN = 4'h4;
  localparam logic [3:0] CMD_HALT = 4'h6;
  localparam logic [3:0] CMD_FREEZE = 4'h7;
  localparam logic [3:0] CMD_ALLOW_COLDSTART = 4'h9;
  // Baud prescaler codes
  localparam logic [1:0] BAUD_10M = 2'h0;
  localparam logic [1:0] BAUD_5M = 2'h1;
  localparam logic [1:0] BAUD_2M5 = 2'h2;
  // Slot modes and wake-up status
  localparam logic [1:0] SLOT_SINGLE = 2'h0;
  localparam logic [1:0] SLOT_ALL = 2'h3;
  localparam logic [2:0] WSV_RX_WUP = 3'h4;
  // Interrupt bit positions
  localparam int IRQ_SFO = 0;
  localparam int IRQ_WST = 1;
  localparam int IRQ_WUPA = 2;
  localparam int IRQ_MRCS = 4;
  localparam int IRQ_W = 5;
  // Timing
  localparam int RATE_HOLD_CYCLES = 3;
  localparam int INIT_SCHED_MT = 16;
  localparam int DYN_IDLE_PHASE = 8;
  // Config reset value
  localparam logic [31:0] CONFIG_RST = 32'h0000_0020;
  typedef enum logic [8:0] {
    ST_DEFAULT_CONFIG = 9'h001,
    ST_CONFIG = 9'h002,
    ST_READY = 9'h004,
    ST_WAKEUP_LISTEN = 9'h008,
    ST_INIT_SCHEDULE = 9'h010,
    ST_INTEG_CHECK = 9'h020,
    ST_ABORT_STARTUP = 9'h040,
    ST_NORMAL_ACTIVE = 9'h080,
    ST_HALT = 9'h100
  } poc_state_t;
endpackage

/* sim/flexray_clock_sync_poc_properties.sv */
// Purpose: Port-level properties of the clock sync and control block
// Assumes: One core_clk domain, rstn asynchronous and active low
// Notes: Attached to every instance through the bind at the foot
`timescale 1ns/100ps
module flexray_clock_sync_poc_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cycle_start,
  input wire logic sync_frame_rx,
  input wire logic [1:0] wus_rx,
  input wire logic dyn_seg_end,
  input wire logic irq,
  input wire logic [11:0] rate_correction,
  input wire logic [10:0] slot_counter,
  input wire logic slot_count_stopped,
  input wire logic loopback_active,
  input wire logic [1:0] baud_code
);
  logic [1:0] starts_seen;
  wire logic irq_cause;
  // Counts cycle starts in every state up to three, so it never lags the block's own count
  assign irq_cause = sync_frame_rx | (|wus_rx) | cycle_start | (pready & pwrite);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      starts_seen <= 2'h0;
    end else if (cycle_start && starts_seen != 2'h3) begin
      starts_seen <= starts_seen + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_access_wait;
    psel && penable && !pready;
  endsequence
  sequence s_stop_hold;
    slot_count_stopped && !cycle_start && !dyn_seg_end;
  endsequence
  a_access_two_cycles: assert property (s_access_wait |=> pready)
    else $error("access not answered after one wait cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  a_rate_held_early: assert property (starts_seen != 2'h3 |-> rate_correction == 12'h000)
    else $error("rate applied too early");
  a_stop_holds_count: assert property (s_stop_hold |=> $stable(slot_counter))
    else $error("slot counter moved while stopped");
  a_loop_only_fast: assert property (loopback_active |-> baud_code == 2'h0)
    else $error("loop-back at a low baud rate");
  a_slot_restart: assert property (cycle_start |=> slot_counter == 11'h001)
    else $error("slot counter not restarted");
  a_irq_has_cause: assert property ($rose(irq) |->
    $past(irq_cause) || $past(irq_cause, 2) || $past(irq_cause, 3))
    else $error("interrupt without an event");
endmodule
bind flexray_clock_sync_poc flexray_clock_sync_poc_props flexray_clock_sync_poc_props_i (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycle_start(cycle_start),
  .sync_frame_rx(sync_frame_rx), .wus_rx(wus_rx), .dyn_seg_end(dyn_seg_end), .irq(irq),
  .rate_correction(rate_correction), .slot_counter(slot_counter),
  .slot_count_stopped(slot_count_stopped), .loopback_active(loopback_active),
  .baud_code(baud_code));

/* sim/cluster_node_model.sv */
// Purpose: Other cluster nodes as seen by the block's link side
// Assumes: Events are one-cycle pulses launched after a rising edge
// Notes: pulse, cstart and rate return at a falling edge so outputs are settled
`timescale 1ns/100ps
module cluster_node_model (
  input wire logic core_clk,
  output logic macrotick,
  output logic cycle_start,
  output logic even_cycle,
  output logic sync_frame_rx,
  output logic startup_frame_rx,
  output logic calc_rate_valid,
  output logic [11:0] calc_rate,
  output logic [15:0] cycle_offset,
  output logic [1:0] wus_rx,
  output logic dyn_frame_end,
  output logic channel_idle,
  output logic dyn_seg_end,
  output logic slot_tick
);
  logic [5:0] ev;
  assign {slot_tick, dyn_seg_end, dyn_frame_end, startup_frame_rx, sync_frame_rx, macrotick} = ev;
  // Quiet link, called once while the block is still in reset
  task automatic idle;
    @(posedge core_clk);
    ev <= 6'h00;
    {cycle_start, even_cycle, calc_rate_valid, wus_rx} <= 5'h00;
    calc_rate <= 12'h000;
    cycle_offset <= 16'h0000;
    channel_idle <= 1'b1;
  endtask
  task automatic settle;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    ev[k] <= 1'b1;
    @(posedge core_clk);
    ev <= 6'h00;
    settle;
  endtask
  task automatic cstart(input logic is_even, input logic [15:0] off);
    @(posedge core_clk);
    {cycle_start, even_cycle, cycle_offset} <= {1'b1, is_even, off};
    @(posedge core_clk);
    // Stale qualifiers inverted so a late sample cannot pass by chance
    {cycle_start, even_cycle, cycle_offset} <= {1'b0, ~is_even, ~off};
    settle;
  endtask
  task automatic rate(input logic [11:0] r);
    @(posedge core_clk);
    {calc_rate_valid, calc_rate} <= {1'b1, r};
    @(posedge core_clk);
    {calc_rate_valid, calc_rate} <= {1'b0, ~r};
    settle;
  endtask
  task automatic wus(input logic [1:0] ch);
    @(posedge core_clk);
    wus_rx <= ch;
    @(posedge core_clk);
    wus_rx <= 2'h0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic busy(input logic b);
    @(posedge core_clk);
    channel_idle <= !b;
  endtask
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for the clock sync and control block
// Assumes: APB master, 50 ns clock, shortened schedule and idle counts
// Notes: Scenarios run in one sequence, each leaving the state for the next
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
  import poc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, err, irq, slot_count_stopped, loopback_active;
  logic macrotick, cycle_start, even_cycle, sync_frame_rx, startup_frame_rx, calc_rate_valid;
  logic dyn_frame_end, channel_idle, dyn_seg_end, slot_tick;
  logic [11:0] calc_rate, rate_correction;
  logic [15:0] cycle_offset;
  logic [1:0] wus_rx, baud_code;
  logic [10:0] slot_counter;
  int errors = 0;
  int comparisons = 0;
  always #25 core_clk = ~core_clk;
  flexray_clock_sync_poc #(.INIT_SCHED_LEN(2), .IDLE_PHASE(3)) flexray_clock_sync_poc_i (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .macrotick(macrotick), .cycle_start(cycle_start), .even_cycle(even_cycle),
    .sync_frame_rx(sync_frame_rx), .startup_frame_rx(startup_frame_rx),
    .calc_rate_valid(calc_rate_valid), .calc_rate(calc_rate), .cycle_offset(cycle_offset),
    .wus_rx(wus_rx), .dyn_frame_end(dyn_frame_end), .channel_idle(channel_idle),
    .dyn_seg_end(dyn_seg_end), .slot_tick(slot_tick), .irq(irq),
    .rate_correction(rate_correction), .slot_counter(slot_counter),
    .slot_count_stopped(slot_count_stopped), .loopback_active(loopback_active),
    .baud_code(baud_code));
  cluster_node_model cluster_node_model_i (
    .core_clk(core_clk), .macrotick(macrotick), .cycle_start(cycle_start),
    .even_cycle(even_cycle), .sync_frame_rx(sync_frame_rx), .startup_frame_rx(startup_frame_rx),
    .calc_rate_valid(calc_rate_valid), .calc_rate(calc_rate), .cycle_offset(cycle_offset),
    .wus_rx(wus_rx), .dyn_frame_end(dyn_frame_end), .channel_idle(channel_idle),
    .dyn_seg_end(dyn_seg_end), .slot_tick(slot_tick));
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic st(input poc_state_t s);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("state", s, q[8:0])
  endtask
  task automatic cmd(input logic [3:0] c);
    apb(1'b1, OFF_CMD, {28'h0, c});
  endtask
  task automatic irq_stat;
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
  endtask
  task automatic t_reset_regs;
    apb(1'b0, OFF_CONFIG, 32'h0);
    `CHK("config", CONFIG_RST, q)
    st(ST_DEFAULT_CONFIG);
    `CHK("inhibit", 1'b1, q[16])
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 33'h1, {q, err})
    apb(1'b1, OFF_RATE, 32'h0000_0FFF);
    apb(1'b0, OFF_RATE, 32'h0);
    `CHK("rate ro", 32'h0, q)
  endtask
  task automatic t_baud;
    for (int b = 0; b < 3; b++) begin
      apb(1'b1, OFF_CONFIG, 32'h0000_502C | 32'(b));
      repeat (2) @(posedge core_clk);
      `CHK("baud", 2'(b), baud_code)
      `CHK("loop", b == 0, loopback_active)
    end
    apb(1'b1, OFF_TIMING, 32'h0000_000A);
    apb(1'b1, OFF_IRQ_EN, 32'h0000_001F);
  endtask
  task automatic t_commands;
    cmd(CMD_CONFIG);
    cmd(CMD_READY);
    st(ST_READY);
    cmd(CMD_ALLOW_COLDSTART);
    st(ST_READY);
    `CHK("inhibit", 1'b0, q[16])
    cmd(CMD_READY);
    st(ST_READY);
    `CHK("inhibit", 1'b0, q[16])
  endtask
  task automatic t_wakeup;
    cmd(CMD_WAKEUP);
    st(ST_WAKEUP_LISTEN);
    repeat (2) cluster_node_model_i.wus(2'h1);
    st(ST_READY);
    `CHK("wsv", WSV_RX_WUP, q[14:12])
    irq_stat;
    `CHK("wake flags", 32'h0000_0006, q)
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, OFF_IRQ_CLR, 32'h0000_001F);
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    cluster_node_model_i.wus(2'h1);
    irq_stat;
    `CHK("third symbol", 32'h0, q)
    cluster_node_model_i.wus(2'h1);
    irq_stat;
    `CHK("fourth symbol", 32'h0000_0004, q)
    `CHK("irq masked", 1'b0, irq)
    repeat (2) cluster_node_model_i.wus(2'h2);
    irq_stat;
    `CHK("channel b", 32'h0000_000C, q)
    apb(1'b1, OFF_IRQ_EN, 32'h0000_001F);
    repeat (2) @(posedge core_clk);
    `CHK("irq unmasked", 1'b1, irq)
    apb(1'b1, OFF_IRQ_CLR, 32'h0000_001F);
    repeat (2) @(posedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  task automatic enter_check;
    cmd(CMD_RUN);
    cluster_node_model_i.pulse(0);
    st(ST_INIT_SCHEDULE);
    cluster_node_model_i.pulse(0);
    st(ST_INTEG_CHECK);
  endtask
  task automatic t_integrate;
    enter_check;
    cmd(CMD_READY);
    enter_check;
    cluster_node_model_i.cstart(1'b1, 16'h0);
    cluster_node_model_i.rate(12'h040);
    `CHK("rate early", 12'h000, rate_correction)
    repeat (3) cluster_node_model_i.pulse(1);
    cluster_node_model_i.pulse(2);
    st(ST_INTEG_CHECK);
    cluster_node_model_i.cstart(1'b0, 16'h0);
    cluster_node_model_i.cstart(1'b1, 16'h0);
    st(ST_INIT_SCHEDULE);
    irq_stat;
    `CHK("overflow", 1'b1, q[IRQ_SFO])
    apb(1'b1, OFF_IRQ_CLR, 32'h0000_001F);
    repeat (2) cluster_node_model_i.pulse(0);
    cluster_node_model_i.cstart(1'b1, 16'h0);
    cluster_node_model_i.pulse(1);
    cluster_node_model_i.pulse(2);
    cluster_node_model_i.cstart(1'b0, 16'h0);
    cluster_node_model_i.cstart(1'b1, 16'h0003);
    st(ST_NORMAL_ACTIVE);
    `CHK("slot mode", SLOT_ALL, q[11:10])
    irq_stat;
    `CHK("missing", 1'b1, q[IRQ_MRCS])
  endtask
  task automatic t_rate;
    cluster_node_model_i.rate(12'h040);
    apb(1'b0, OFF_RATE, 32'h0);
    `CHK("rate status", 32'h0000_0040, q)
    `CHK("rate applied", 12'h040, rate_correction)
    // Damped value must replace a nonzero applied one
    cluster_node_model_i.rate(12'hFFB);
    apb(1'b0, OFF_RATE, 32'h0);
    `CHK("damped status", 32'h0, q)
    `CHK("damped applied", 12'h000, rate_correction)
  endtask
  task automatic t_dynamic;
    cluster_node_model_i.cstart(1'b0, 16'h0);
    `CHK("slot restart", 11'h001, slot_counter)
    repeat (2) cluster_node_model_i.pulse(5);
    cluster_node_model_i.busy(1'b1);
    cluster_node_model_i.pulse(3);
    repeat (5) @(posedge core_clk);
    cluster_node_model_i.busy(1'b0);
    cluster_node_model_i.pulse(5);
    `CHK("stopped", 1'b1, slot_count_stopped)
    `CHK("slot held", 11'h003, slot_counter)
    cluster_node_model_i.pulse(4);
    `CHK("resumed", 1'b0, slot_count_stopped)
  endtask
  task automatic t_halt;
    cmd(CMD_HALT);
    st(ST_HALT);
    `CHK("halt slot", SLOT_ALL, q[11:10])
    cmd(CMD_FREEZE);
    st(ST_HALT);
    `CHK("freeze slot", SLOT_ALL, q[11:10])
    cmd(CMD_CONFIG);
    st(ST_DEFAULT_CONFIG);
    `CHK("single slot", SLOT_SINGLE, q[11:10])
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    cluster_node_model_i.idle;
    repeat (15) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset_regs;
    t_baud;
    t_commands;
    t_wakeup;
    t_integrate;
    t_rate;
    t_dynamic;
    t_halt;
    tally_and_finish;
  end
  // About fifty times the expected run, so slow answers are not cut short
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish;
  end
endmodule
